// [design/sbrp_defs.vh]
// Purpose: Constants for the synchronous burst read port
// Assumes: 200 MHz system clock, 16-bit word address bus
// Notes: Burst length codes follow the config word layout chosen here
`ifndef SBRP_DEFS_VH
`define SBRP_DEFS_VH
`define SBRP_ADDR_W 16
`define SBRP_DATA_W 16
`define SBRP_LAT_RESET 3'h4
`define SBRP_LAT_MIN 3'h3
`define SBRP_LAT_MAX 3'h7
`define SBRP_BL_CONT 3'h0
`define SBRP_BL_4 3'h1
`define SBRP_BL_8 3'h2
`define SBRP_BL_16 3'h3
`define SBRP_BL_32 3'h4
`define SBRP_CFG_ADDR 16'hF221
`define SBRP_CFG_RM_BIT 15
`define SBRP_CFG_LAT_LSB 12
`define SBRP_CFG_BL_LSB 9
`endif

// [design/sbrp_sync3.v]
// Purpose: Three-stage synchroniser for pins from outside the clock domain
// Assumes: Stage one feeds only stage two
// Notes: A change is accepted once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sbrp_sync3
(
	input wire clock,
	input wire nrst,
	input wire reset_value,
	input wire pin,
	output reg level_q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	// Filtered level only moves when the last two stages match
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			// Idle level of the pin, so no false edge follows reset
			level_q <= reset_value;
		end
		else
		begin
			s1_q <= pin ^ reset_value;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level_q <= s3_q ^ reset_value;
		end
	end
endmodule
`default_nettype wire

// [design/sbrp_port.v]
// Purpose: Synchronous burst read side of a multiplexed flash host port
// Assumes: Host drives chip_sel_n, out_en_n, write_en_n, address_valid_strobe_n, burst_clk
// Notes: Memory contents come from the core over mem_addr/mem_rdata with same-cycle data
`timescale 1ns/1ps
`default_nettype none
`include "sbrp_defs.vh"
// How it works
// - In synchronous mode data steps on the burst clock, not on the strobe.
// - Continuous burst counts upward from the start address, wrapping only from FFFF to 0000.
// - Fixed bursts of 4/8/16/32 wrap inside their aligned group.
// - First word is fetched at once but valid only after the latency count; later words follow each rise.
// - Latency count resets to four and accepts three to seven.
// - With n latency cycles, first data is valid on edge n+1.
// - Each later rising edge outputs the next word and advances the counter.
// - Ready rises with the data fetch clock of the first valid word.
// - A clocked access in asynchronous mode still returns the first word.
// - Chip select high, reset pin low, internal reset or write pulse ends a burst.
// - Latency count reads back through a strobed address in burst mode.
// - Chip select or output enable high releases the data outputs.
// - After reset the port starts in asynchronous mode.
module sbrp_port
(
	input wire clock,
	input wire nrst,
	input wire hardware_reset_n,
	input wire chip_sel_n,
	input wire out_en_n,
	input wire write_en_n,
	input wire address_valid_strobe_n,
	input wire burst_clk,
	input wire [15:0] addr_dq_in,
	input wire internal_reset,
	input wire [15:0] mem_rdata,
	output reg [15:0] mem_addr_q,
	output reg [15:0] dq_out_q,
	output reg dq_oe_q,
	output reg ready_q,
	output reg read_mode_select_q,
	output reg [2:0] read_latency_count_q
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_BURST = 2'h2;

	wire rst_pin_f;
	wire ce_n_f;
	wire oe_n_f;
	wire we_n_f;
	wire avd_n_f;
	wire clk_f;
	reg [15:0] a1_q;
	reg [15:0] a2_q;
	reg [15:0] a3_q;
	reg [15:0] addr_f_q;
	reg clk_prev_q;
	reg we_prev_q;
	reg avd_prev_q;
	reg [1:0] state_q;
	reg [2:0] lat_cnt_q;
	reg [15:0] start_q;
	reg [4:0] off_q;
	reg [2:0] burst_len_q;
	reg [15:0] next_addr;
	reg [4:0] wrap_mask;

	// Control pins pass three flops; reset values match the idle pin level
	sbrp_sync3 u_rst
	(
		.clock(clock),
		.nrst(nrst),
		.reset_value(1'b1),
		.pin(hardware_reset_n),
		.level_q(rst_pin_f)
	);
	sbrp_sync3 u_ce
	(
		.clock(clock),
		.nrst(nrst),
		.reset_value(1'b1),
		.pin(chip_sel_n),
		.level_q(ce_n_f)
	);
	sbrp_sync3 u_oe
	(
		.clock(clock),
		.nrst(nrst),
		.reset_value(1'b1),
		.pin(out_en_n),
		.level_q(oe_n_f)
	);
	sbrp_sync3 u_we
	(
		.clock(clock),
		.nrst(nrst),
		.reset_value(1'b1),
		.pin(write_en_n),
		.level_q(we_n_f)
	);
	sbrp_sync3 u_avd
	(
		.clock(clock),
		.nrst(nrst),
		.reset_value(1'b1),
		.pin(address_valid_strobe_n),
		.level_q(avd_n_f)
	);
	sbrp_sync3 u_clk
	(
		.clock(clock),
		.nrst(nrst),
		.reset_value(1'b0),
		.pin(burst_clk),
		.level_q(clk_f)
	);

	// Address bus: three stages, accepted when the last two agree
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			a1_q <= 16'h0000;
			a2_q <= 16'h0000;
			a3_q <= 16'h0000;
			addr_f_q <= 16'h0000;
		end
		else
		begin
			a1_q <= addr_dq_in;
			a2_q <= a1_q;
			a3_q <= a2_q;
			if (a2_q == a3_q)
				addr_f_q <= a3_q;
		end
	end

	wire clk_rise = clk_f & ~clk_prev_q;
	wire we_pulse = ~we_n_f & we_prev_q;
	wire avd_low = ~avd_n_f;
	// The strobe rises after every capture, so only a fresh fall may restart
	wire avd_fall = ~avd_n_f & avd_prev_q;
	// Any of these ends the burst at once
	wire stop = ce_n_f | ~rst_pin_f | internal_reset | we_pulse;
	// Register address was latched with the strobe; the bus now holds write data
	wire cfg_write = we_pulse & ~ce_n_f & (start_q == `SBRP_CFG_ADDR);
	wire [2:0] lat_wr = addr_f_q[`SBRP_CFG_LAT_LSB+2:`SBRP_CFG_LAT_LSB];

	// Wrap mask picks the bits that count inside the aligned group
	always @*
	begin
		case (burst_len_q)
			`SBRP_BL_4: wrap_mask = 5'h03;
			`SBRP_BL_8: wrap_mask = 5'h07;
			`SBRP_BL_16: wrap_mask = 5'h0F;
			`SBRP_BL_32: wrap_mask = 5'h1F;
			default: wrap_mask = 5'h00;
		endcase
	end

	// Next word address: linear in continuous mode, wrapped for 4/8/16/32, held at the start address for other codes
	always @*
	begin
		if (burst_len_q == `SBRP_BL_CONT)
			next_addr = mem_addr_q + 16'h0001;
		else
			next_addr = {start_q[15:5],
				(start_q[4:0] & ~wrap_mask) | ((start_q[4:0] + off_q + 5'h01) & wrap_mask)};
	end

	// Configuration word; note data for writes shares the muxed bus
	always @(posedge clock)
	begin
		if (!nrst || !rst_pin_f || internal_reset)
		begin
			read_mode_select_q <= 1'b0; // Asynchronous after any reset
			read_latency_count_q <= `SBRP_LAT_RESET;
			burst_len_q <= `SBRP_BL_CONT;
			we_prev_q <= 1'b1;
		end
		else
		begin
			we_prev_q <= we_n_f;
			if (cfg_write)
			begin
				read_mode_select_q <= addr_f_q[`SBRP_CFG_RM_BIT];
				// Out-of-range values are ignored to keep the count legal
				if (lat_wr >= `SBRP_LAT_MIN)
					read_latency_count_q <= lat_wr;
				burst_len_q <= addr_f_q[`SBRP_CFG_BL_LSB+2:`SBRP_CFG_BL_LSB];
			end
		end
	end

	// Burst sequencer: capture, latency wait, then one word per clock rise
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			state_q <= ST_IDLE;
			lat_cnt_q <= 3'h0;
			start_q <= 16'h0000;
			off_q <= 5'h00;
			mem_addr_q <= 16'h0000;
			ready_q <= 1'b0;
			clk_prev_q <= 1'b0;
			avd_prev_q <= 1'b1;
		end
		else
		begin
			clk_prev_q <= clk_f;
			avd_prev_q <= avd_n_f;
			if (stop)
			begin
				state_q <= ST_IDLE;
				ready_q <= 1'b0;
			end
			else
			begin
				case (state_q)
					ST_IDLE:
					begin
						ready_q <= 1'b0;
						// Address is latched by the strobe; first word fetched now
						if (avd_low)
						begin
							start_q <= addr_f_q;
							mem_addr_q <= addr_f_q;
							off_q <= 5'h00;
						end
						// Clocked access in synchronous mode starts the latency count
						if (avd_low && clk_rise && read_mode_select_q)
						begin
							state_q <= ST_WAIT;
							lat_cnt_q <= read_latency_count_q;
						end
					end
					ST_WAIT:
					begin
						ready_q <= 1'b0; // Held low through latency
						if (clk_rise)
						begin
							// Edge n after the capture edge presents word one
							if (lat_cnt_q == 3'h1)
							begin
								state_q <= ST_BURST;
								ready_q <= 1'b1;
							end
							lat_cnt_q <= lat_cnt_q - 3'h1;
						end
					end
					ST_BURST:
					begin
						// Ready marks only the first word
						if (clk_rise)
						begin
							ready_q <= 1'b0;
							mem_addr_q <= next_addr;
							off_q <= off_q + 5'h01;
						end
					end
					default:
					begin
						state_q <= ST_IDLE;
						ready_q <= 1'b0;
					end
				endcase
				// A new falling strobe while busy restarts the access
				if (avd_fall && state_q != ST_IDLE)
					state_q <= ST_IDLE;
			end
		end
	end

	// Output drive; config address returns the latency count
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			dq_out_q <= 16'h0000;
			dq_oe_q <= 1'b0;
		end
		else
		begin
			// Strobe low means the muxed bus carries an address, so stay off
			dq_oe_q <= ~ce_n_f & ~oe_n_f & we_n_f & avd_n_f;
			if (mem_addr_q == `SBRP_CFG_ADDR)
			begin
				dq_out_q <= 16'h0000;
				dq_out_q[`SBRP_CFG_RM_BIT] <= read_mode_select_q;
				dq_out_q[`SBRP_CFG_LAT_LSB+2:`SBRP_CFG_LAT_LSB] <= read_latency_count_q;
				dq_out_q[`SBRP_CFG_BL_LSB+2:`SBRP_CFG_BL_LSB] <= burst_len_q;
			end
			else
				dq_out_q <= mem_rdata;
		end
	end
endmodule
`default_nettype wire

// [tb/sbrp_chk.sv]
// Purpose: Port checks for the burst read port
// Assumes: Pins reach the clock domain within five cycles
// Notes: Eight clocks of a steady pin counts as settled
`timescale 1ns/1ps
`default_nettype none
module sbrp_chk
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic hardware_reset_n,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic internal_reset,
	input wire logic dq_oe_q,
	input wire logic ready_q,
	input wire logic read_mode_select_q,
	input wire logic [2:0] read_latency_count_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Reset state and latency range
	mode_after_rst_a: assert property ($rose(nrst) |-> !read_mode_select_q)
		else $error("mode not async after reset");
	lat_after_rst_a: assert property ($rose(nrst) |-> read_latency_count_q == 3'h4)
		else $error("latency not four after reset");
	lat_range_a: assert property (read_latency_count_q >= 3'h3)
		else $error("latency below three");
	// Deselect or output disable releases the bus; sync delay leaves margin
	oe_ce_off_a: assert property (chip_sel_n [*8] |-> !dq_oe_q)
		else $error("driving while deselected");
	oe_oe_off_a: assert property (out_en_n [*8] |-> !dq_oe_q)
		else $error("driving while output disabled");
	ce_stop_rdy_a: assert property (chip_sel_n [*8] |-> !ready_q)
		else $error("ready after burst ended");
	// Reset pin and internal reset, which end a burst, also drop the configuration
	hw_rst_mode_a: assert property ($fell(hardware_reset_n) |-> ##[1:8] !read_mode_select_q)
		else $error("reset pin kept sync mode");
	int_rst_cfg_a: assert property (internal_reset |-> ##[0:2]
		(read_latency_count_q == 3'h4 && !read_mode_select_q))
		else $error("internal reset kept config");
	// Ready only marks a word of a synchronous burst
	rdy_sync_only_a: assert property (ready_q |-> read_mode_select_q)
		else $error("ready raised outside sync mode");
endmodule
bind sbrp_port sbrp_chk u_chk
(
	.clock(clock), .nrst(nrst), .hardware_reset_n(hardware_reset_n),
	.chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .internal_reset(internal_reset),
	.dq_oe_q(dq_oe_q), .ready_q(ready_q), .read_mode_select_q(read_mode_select_q),
	.read_latency_count_q(read_latency_count_q)
);
`default_nettype wire

// [tb/sbrp_host.sv]
// Purpose: Host burst clock source
// Assumes: Bench drives the other host pins
// Notes: Offset start keeps edges off the system clock
`timescale 1ns/1ps
`default_nettype none
module sbrp_host
(
	input wire logic run,
	output logic burst_clk
);
	// 160 ns is far below 40 MHz, so latency three is legal; stands low between frames
	initial
	begin
		burst_clk = 1'b0;
		#13;
		forever #80 burst_clk = run ? ~burst_clk : 1'b0;
	end
endmodule
`default_nettype wire

// [tb/sbrp_port_test.sv]
// Purpose: Self-checking bench for the burst read port
// Assumes: Core data is the word address xor 5a5a
// Notes: Pins are synced, so each change gets eight clocks to settle
`timescale 1ns/1ps
`default_nettype none
module sbrp_port_test;
	logic clock = 0, nrst = 0, hrst_n = 1, ce_n = 1, oe_n = 1, we_n = 1, avd_n = 1;
	logic irst = 0, run = 0;
	logic [15:0] ad = 0;
	wire logic [15:0] maddr, dq;
	wire logic oe, rdy, mode, bclk;
	wire logic [2:0] lat;
	int fail_count = 0, n_compared = 0, nrdy = 0;
	always #2.5 clock = ~clock;
	// Count ready rises so an early one shows up
	always @(posedge rdy) nrdy++;
	sbrp_host u_host (.run(run), .burst_clk(bclk));
	sbrp_port u_dut (.clock(clock), .nrst(nrst), .hardware_reset_n(hrst_n), .chip_sel_n(ce_n),
		.out_en_n(oe_n), .write_en_n(we_n), .address_valid_strobe_n(avd_n), .burst_clk(bclk),
		.addr_dq_in(ad), .internal_reset(irst), .mem_rdata(maddr ^ 16'h5a5a),
		.mem_addr_q(maddr), .dq_out_q(dq), .dq_oe_q(oe), .ready_q(rdy),
		.read_mode_select_q(mode), .read_latency_count_q(lat));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("compared=%0d failed=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Host pins change together, then settle through the syncs
	task pins(input logic c, o, w, a, input logic [15:0] v);
		@(posedge clock);
		ce_n <= c;
		oe_n <= o;
		we_n <= w;
		avd_n <= a;
		ad <= v;
		repeat (8) @(posedge clock);
	endtask
	// Bounded wait for the next burst clock rise, seen on the system clock
	task wait_bclk;
		int k;
		logic prev;
		prev = bclk;
		for (k = 0; k < 64; k++)
		begin
			@(posedge clock);
			if (bclk === 1'b1 && prev === 1'b0)
				break;
			prev = bclk;
		end
		if (k == 64)
		begin
			fail_count++;
			stop_test;
		end
	endtask
	task step;
		wait_bclk;
		repeat (10) @(posedge clock);
	endtask
	task cfg(input logic m, input logic [2:0] l, b);
		pins(0, 1, 1, 0, 16'hf221);
		pins(0, 1, 1, 1, {m, l, b, 9'h000});
		pins(0, 1, 0, 1, {m, l, b, 9'h000});
		pins(1, 1, 1, 1, 0);
	endtask
	task t_async;
		chk(mode, 0);
		chk(lat, 4);
		pins(0, 0, 1, 0, 16'h0345);
		run <= 1;
		step;
		chk(maddr, 16'h0345);
		chk(dq, 16'h0345 ^ 16'h5a5a);
		pins(1, 1, 1, 1, 0);
		run <= 0;
	endtask
	task t_burst(input logic [2:0] l, b, input logic [15:0] s);
		int n0;
		logic [15:0] m, e;
		m = (b == 0) ? 16'hffff : 16'((16'h0002 << b) - 1);
		n0 = nrdy;
		cfg(1, l, b);
		pins(0, 0, 1, 0, s);
		run <= 1;
		wait_bclk;
		pins(0, 0, 1, 1, s);
		for (int i = 1; i <= l + 4; i++)
		begin
			step;
			e = 16'((s & ~m) | ((s + i - l) & m));
			if (i == l - 1)
				chk(nrdy - n0, 0);
			if (i >= l)
			begin
				chk(nrdy - n0, 1);
				chk(maddr, e);
				chk(dq, e ^ 16'h5a5a);
				chk(oe, 1);
			end
		end
		pins(1, 1, 1, 1, 0);
		chk(oe, 0);
		step;
		chk(maddr, e);
		run <= 0;
	endtask
	task t_cfg;
		cfg(1, 5, 0);
		cfg(1, 2, 0);
		chk(lat, 5);
		pins(0, 0, 1, 0, 16'hf221);
		run <= 1;
		wait_bclk;
		pins(0, 0, 1, 1, 16'hf221);
		repeat (5) step;
		chk(rdy, 1);
		chk(oe, 1);
		chk(dq[14:12], 5);
		chk(dq[15], 1);
		pins(1, 1, 1, 1, 0);
		run <= 0;
	endtask
	task t_rst;
		cfg(1, 6, 0);
		chk(lat, 6);
		chk(mode, 1);
		hrst_n <= 0;
		pins(1, 1, 1, 1, 0);
		chk(mode, 0);
		chk(lat, 4);
		hrst_n <= 1;
		cfg(1, 6, 0);
		chk(lat, 6);
		irst <= 1;
		pins(1, 1, 1, 1, 0);
		irst <= 0;
		chk(lat, 4);
		chk(mode, 0);
	endtask
	// Bursts cover every length code, two latency ends and wrap points
	initial
	begin
		repeat (3) @(posedge clock);
		nrst <= 1;
		repeat (4) @(posedge clock);
		t_async;
		t_burst(4, 0, 16'h05fe);
		t_burst(3, 1, 16'h0202);
		t_burst(5, 2, 16'h0206);
		t_burst(6, 3, 16'h020e);
		t_burst(7, 4, 16'h021e);
		t_cfg;
		t_rst;
		stop_test;
	end
	// A stuck clock or handshake ends the run as a failure
	initial
	begin
		repeat (50000) @(posedge clock);
		fail_count++;
		stop_test;
	end
endmodule
`default_nettype wire
